// *** verilog/mode_select_low_power_ctrl.sv ***
// operating mode selection and stop/halt/wait sequencing with apb registers
// Functional notes
// R01 - sample mode pins at reset rising edge
// R02 - vpp plus high capture pin selects bootloader
// R03 - normal irq level selects user mode
// R04 - watchdog reset ignores live capture pin
// R05 - latch capture pin each external reset
// R06 - stop gives stop or halt by option
// R07 - stop mode gates oscillator and watchdog
// R08 - stop clears cpu interrupt mask
// R09 - low-power states preserve all other state; the ctrl register still returns to ctrl_reset in low power
// R10 - stop exit by irq/reset, 4064 delay
// R11 - halt stops cpu clock, timers run
// R12 - halt exit on timer, irq, reset
// R13 - halt exit delay from running counter
// R14 - wait stops cpu clock, timers run
// R15 - wait clears cpu interrupt mask
// R16 - wait exit on timer, irq, reset
// R17 - watchdog runs only when option set
// R18 - set stop-to-halt if watchdog always needed
// R19 - disable watchdog for long waits
// R20 - bootloader image uses eprom addresses
// R21 - writing zero to bit0 clears watchdog
// R22 - halt exit immediate at terminal count
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module mode_select_low_power_ctrl (
   input wire logic pclk, // 20 mhz clock
   input wire logic presetn, // async reset, active low
   input wire logic [11:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic ext_reset_n, // external reset pin, active low
   input wire logic irq_vpp_high, // irq pin at programming voltage
   input wire logic capture_mode_select_pin, // capture/mode-select pin level
   input wire logic irq_n, // external interrupt pin, active low
   input wire logic watchdog_reset, // watchdog timeout reset pulse
   input wire logic timer_irq, // enabled 16-bit timer interrupt
   input wire logic stop_instr, // cpu executes stop, pulse
   input wire logic wait_instr, // cpu executes wait, pulse
   input wire logic stop_to_halt_option, // option byte bit
   input wire logic watchdog_enable_option, // option byte bit
   output logic bootloader_mode, // 1 bootloader, 0 user mode
   output logic osc_enable, // oscillator running
   output logic cpu_clk_enable, // cpu and bus clock running
   output logic timer_clk_enable, // timer clocks running
   output logic clear_imask, // clear cpu interrupt mask, pulse
   output logic watchdog_run, // watchdog counter may count
   output logic watchdog_clear // clear watchdog counter, pulse
);
   import mode_lp_pkg::*;

   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] vpp_sync;
      logic [1:0] cap_sync;
      logic [1:0] irq_sync;
      logic rst_prev;
      logic cap_latch;
      logic boot;
      power_state_e pstate;
      resume_e resume;
      logic imask_pulse;
      logic wd_clr;
      logic [1:0] ctrl;
      logic [31:0] rdata;
   } ctrl_s;

   ctrl_s q;
   ctrl_s next_q;
   logic stab_end;
   logic stab_restart;
   logic stab_run;
   logic setup;
   logic access;
   logic rst_rise;
   logic irq_seen;
   logic soft_stop;
   logic soft_wait;

   // stabilization delay counter, free running except in stop
   stab_counter #(
      .width(stab_w)
   ) u_stab (
      .pclk(pclk),
      .presetn(presetn),
      .run(stab_run),
      .restart(stab_restart),
      .last(stab_last),
      .at_end(stab_end)
   );

   // synchronised pin levels and derived events
   assign rst_rise = q.rst_sync[1] & ~q.rst_prev; // R01
   assign irq_seen = ~q.irq_sync[1];
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign soft_stop = q.ctrl[0];
   assign soft_wait = q.ctrl[1];
   assign stab_run = (q.pstate != st_stop); // R07
   assign stab_restart = (q.pstate == st_stop) & (irq_seen | rst_rise); // R10

   always_comb begin
      next_q = q;
      next_q.imask_pulse = 1'b0;
      next_q.wd_clr = 1'b0;
      // two-flop synchronisers for pin inputs
      next_q.rst_sync = {q.rst_sync[0], ext_reset_n};
      next_q.vpp_sync = {q.vpp_sync[0], irq_vpp_high};
      next_q.cap_sync = {q.cap_sync[0], capture_mode_select_pin};
      next_q.irq_sync = {q.irq_sync[0], irq_n};
      next_q.rst_prev = q.rst_sync[1];
      // mode selection at external reset release and at watchdog reset
      if (rst_rise) begin
         next_q.cap_latch = q.cap_sync[1]; // R05
         next_q.boot = q.vpp_sync[1] & q.cap_sync[1]; // R02 R03
      end else if (watchdog_reset) begin
         next_q.boot = q.vpp_sync[1] & q.cap_latch; // R04
      end
      // power state sequencing; in low power ctrl returns to ctrl_reset, other state is untouched
      unique case (q.pstate)
         st_run: begin
            if ((stop_instr | soft_stop) && q.resume == rs_run) begin
               next_q.imask_pulse = 1'b1; // R08
               if (stop_to_halt_option) begin
                  next_q.pstate = st_halt; // R06
               end else begin
                  next_q.pstate = st_stop; // R06
               end
            end else if ((wait_instr | soft_wait) && q.resume == rs_run) begin
               next_q.imask_pulse = 1'b1; // R15
               next_q.pstate = st_wait; // R14
            end
         end
         st_stop: begin
            if (irq_seen | rst_rise) begin
               next_q.pstate = st_run; // R10
               next_q.resume = rs_delay;
            end
         end
         st_halt: begin
            if (timer_irq | irq_seen | rst_rise | watchdog_reset) begin
               next_q.pstate = st_run; // R12
               next_q.resume = stab_end ? rs_run : rs_halt_exit; // R13 R22
            end
         end
         st_wait: begin
            if (timer_irq | irq_seen | rst_rise | watchdog_reset) begin
               next_q.pstate = st_run; // R16
            end
         end
      endcase
      // clock held off until stabilization counter ends
      if (q.resume != rs_run && stab_end) begin
         next_q.resume = rs_run; // R10 R13
      end
      // register writes take effect in the access cycle, read data is captured in the setup cycle
      if (access && pwrite) begin
         if (paddr == addr_ctrl) begin
            next_q.ctrl = pwdata[1:0];
         end else if (paddr == addr_wdclr && !pwdata[0]) begin
            next_q.wd_clr = 1'b1; // R21
         end
      end else if (q.pstate != st_run) begin
         next_q.ctrl = ctrl_reset;
      end
      if (setup) begin
         if (paddr == addr_ctrl) begin
            next_q.rdata = {30'h0, q.ctrl};
         end else if (paddr == addr_status) begin
            next_q.rdata = {24'h0, q.cap_latch, stab_end, q.resume, q.pstate,
                            watchdog_run, q.boot};
         end else begin
            next_q.rdata = 32'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.rst_sync <= 2'h3;
         q.rst_prev <= 1'b1;
         q.irq_sync <= 2'h3;
         q.pstate <= st_run;
         q.resume <= rs_run;
         q.ctrl <= ctrl_reset;
      end else begin
         q <= next_q;
      end
   end

   // apb answer: one wait-free access phase, error on unmapped address
   assign pready = 1'b1;
   assign pslverr = access & (paddr != addr_ctrl) & (paddr != addr_status) &
                    (paddr != addr_wdclr);
   assign prdata = q.rdata;
   // clock gating outputs
   assign bootloader_mode = q.boot;
   assign osc_enable = (q.pstate != st_stop); // R07
   assign cpu_clk_enable = (q.pstate == st_run) & (q.resume == rs_run); // R11 R14 R09
   assign timer_clk_enable = (q.pstate != st_stop) & (q.resume != rs_delay); // R11 R14
   assign clear_imask = q.imask_pulse;
   // watchdog only in user mode with option set, frozen in stop
   assign watchdog_run = watchdog_enable_option & ~q.boot & ~q.vpp_sync[1] &
                         (q.pstate != st_stop); // R17 R07
   assign watchdog_clear = q.wd_clr; // R21
endmodule : mode_select_low_power_ctrl

// *** verilog/mode_lp_pkg.sv ***
// constants and types for the mode select and low-power controller
package mode_lp_pkg;
   // oscillator stabilization delay, internal clock cycles
   localparam int stab_cycles = 4064;
   localparam int stab_w = 12;
   localparam logic [stab_w-1:0] stab_last = 12'hfdf; // 4064 - 1
   // register map
   localparam logic [11:0] addr_ctrl = 12'h000;
   localparam logic [11:0] addr_status = 12'h004;
   localparam logic [11:0] addr_wdclr = 12'h008;
   localparam logic [1:0] ctrl_reset = 2'h0;
   // power states
   typedef enum logic [1:0] {
      st_run = 2'b00,
      st_stop = 2'b01,
      st_halt = 2'b10,
      st_wait = 2'b11
   } power_state_e;
   typedef enum logic [1:0] {
      rs_run = 2'b00,
      rs_delay = 2'b01,
      rs_halt_exit = 2'b10
   } resume_e;
endpackage : mode_lp_pkg

// *** verilog/stab_counter.sv ***
// free-running oscillator stabilization delay counter
`timescale 1ns/1ps
module stab_counter #(
   parameter int width = 12
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic run, // oscillator running
   input wire logic restart, // restart count at zero
   input wire logic [width-1:0] last, // terminal count
   output logic at_end // terminal count reached
);
   import mode_lp_pkg::*;
   typedef struct packed {
      logic [width-1:0] count;
   } cnt_s;
   cnt_s q;
   cnt_s next_q;
   // wraps at terminal count, frozen when oscillator stops
   always_comb begin
      next_q = q;
      if (restart) begin
         next_q.count = '0;
      end else if (run) begin
         if (q.count == last) begin
            next_q.count = '0;
         end else begin
            next_q.count = q.count + 1'b1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   assign at_end = (q.count == last);
endmodule : stab_counter

// *** tb/mode_lp_assertions.sv ***
// port checks for the mode select and low-power controller
`timescale 1ns/1ps
module mode_lp_assertions
   import mode_lp_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic [11:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   input wire logic pslverr, // apb error
   input wire logic stop_instr, // stop pulse
   input wire logic wait_instr, // wait pulse
   input wire logic stop_to_halt_option, // option bit
   input wire logic watchdog_enable_option, // option bit
   input wire logic osc_enable, // oscillator on
   input wire logic cpu_clk_enable, // cpu clock on
   input wire logic timer_clk_enable, // timer clocks on
   input wire logic clear_imask, // mask clear pulse
   input wire logic watchdog_run, // watchdog may count
   input wire logic watchdog_clear // watchdog clear pulse
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [12:0] dly; // cycles since oscillator restart
   logic from_stop; // restart after stop pending
   // count the stabilization wait after stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly <= '0;
         from_stop <= 1'b0;
      end else begin
         from_stop <= !osc_enable || (from_stop && !cpu_clk_enable);
         dly <= (from_stop && osc_enable) ? dly + 13'd1 : '0;
      end
   end
   property p_stop_mask; stop_instr && cpu_clk_enable |=> clear_imask; endproperty
   a_stop_mask: assert property (p_stop_mask) else $error("mask not cleared");
   property p_stop_osc;
      stop_instr && cpu_clk_enable && !stop_to_halt_option |=> !osc_enable && !cpu_clk_enable;
   endproperty
   a_stop_osc: assert property (p_stop_osc) else $error("stop kept clock");
   property p_halt;
      stop_instr && cpu_clk_enable && stop_to_halt_option
         |=> osc_enable && timer_clk_enable && !cpu_clk_enable;
   endproperty
   a_halt: assert property (p_halt) else $error("bad halt clocks");
   property p_wait;
      wait_instr && cpu_clk_enable |=> clear_imask && timer_clk_enable && !cpu_clk_enable;
   endproperty
   a_wait: assert property (p_wait) else $error("bad wait entry");
   property p_wd_opt; !watchdog_enable_option |-> !watchdog_run; endproperty
   a_wd_opt: assert property (p_wd_opt) else $error("watchdog ran");
   property p_wd_stop; !osc_enable |-> !watchdog_run; endproperty
   a_wd_stop: assert property (p_wd_stop) else $error("watchdog ran in stop");
   property p_wd_clr;
      psel && penable && pwrite && paddr == addr_wdclr && !pwdata[0] |-> ##[1:2] watchdog_clear;
   endproperty
   a_wd_clr: assert property (p_wd_clr) else $error("no watchdog clear");
   property p_stop_exit; from_stop && cpu_clk_enable |-> dly >= 13'd4058 && dly <= 13'd4070;
   endproperty
   a_stop_exit: assert property (p_stop_exit) else $error("bad stop exit delay");
   property p_slverr; psel && penable && paddr > addr_wdclr |-> pslverr; endproperty
   a_slverr: assert property (p_slverr) else $error("no error on unmapped");
   cover property (stop_instr && !stop_to_halt_option);
   cover property (stop_instr && stop_to_halt_option);
   cover property (from_stop && cpu_clk_enable);
endmodule : mode_lp_assertions
bind mode_select_low_power_ctrl mode_lp_assertions u_mode_lp_assertions (.pclk, .presetn,
   .paddr, .psel, .penable, .pwrite, .pwdata, .pslverr, .stop_instr, .wait_instr,
   .stop_to_halt_option, .watchdog_enable_option, .osc_enable, .cpu_clk_enable,
   .timer_clk_enable, .clear_imask, .watchdog_run, .watchdog_clear);

// *** tb/cpu_pin_model.sv ***
// cpu core and pin model on the far side of the controller
`timescale 1ns/1ps
module cpu_pin_model (
   input wire logic pclk, // clock
   output logic ext_reset_n, // reset pin, active low
   output logic irq_vpp_high, // programming voltage
   output logic capture_mode_select_pin, // mode pin
   output logic irq_n, // interrupt, active low
   output logic watchdog_reset, // watchdog pulse
   output logic timer_irq, // timer interrupt
   output logic stop_instr, // stop pulse
   output logic wait_instr // wait pulse
);
   // idle pin levels
   initial begin
      {ext_reset_n, irq_n, irq_vpp_high, capture_mode_select_pin} = 4'hc;
      {watchdog_reset, timer_irq, stop_instr, wait_instr} = 4'h0;
   end
   // one-cycle strobe: 0 stop, 1 wait, 2 watchdog, 3 reset pin
   task automatic pulse(input int k);
      @(posedge pclk);
      case (k)
         0: stop_instr <= 1'b1;
         1: wait_instr <= 1'b1;
         2: watchdog_reset <= 1'b1;
         default: ext_reset_n <= 1'b0;
      endcase
      @(posedge pclk);
      {stop_instr, wait_instr, watchdog_reset, ext_reset_n} <= 4'h1;
   endtask : pulse
endmodule : cpu_pin_model

// *** tb/mode_select_low_power_ctrl_bench.sv ***
// self-checking bench for the mode select and low-power controller
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
   $display("Error at %0t got %h expected %h", $time, (a), (e)); end end
module mode_select_low_power_ctrl_bench;
   import mode_lp_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic stop_to_halt_option, watchdog_enable_option, ext_reset_n, irq_vpp_high;
   logic capture_mode_select_pin, irq_n, watchdog_reset, timer_irq, stop_instr, wait_instr;
   logic bootloader_mode, osc_enable, cpu_clk_enable, timer_clk_enable, clear_imask;
   logic watchdog_run, watchdog_clear;
   int fails, check_count, n, latch;
   mode_select_low_power_ctrl u_mode_select_low_power_ctrl (.pclk, .presetn, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ext_reset_n, .irq_vpp_high,
      .capture_mode_select_pin, .irq_n, .watchdog_reset, .timer_irq, .stop_instr, .wait_instr,
      .stop_to_halt_option, .watchdog_enable_option, .bootloader_mode, .osc_enable,
      .cpu_clk_enable, .timer_clk_enable, .clear_imask, .watchdog_run, .watchdog_clear);
   cpu_pin_model u_cpu_pin_model (.pclk, .ext_reset_n, .irq_vpp_high, .capture_mode_select_pin,
      .irq_n, .watchdog_reset, .timer_irq, .stop_instr, .wait_instr);
   // 50 ns clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // one apb transfer, waits for ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask : apb
   // count cycles until the cpu clock returns
   task automatic wake;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (cpu_clk_enable !== 1'b1);
      {u_cpu_pin_model.irq_n, u_cpu_pin_model.timer_irq} <= 2'h2;
   endtask : wake
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   // hang guard
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      stop_test;
   end
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {stop_to_halt_option, watchdog_enable_option} = 2'h1;
      void'($urandom(32'h237d));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         {u_cpu_pin_model.capture_mode_select_pin, u_cpu_pin_model.irq_vpp_high} <= i[1:0];
         u_cpu_pin_model.pulse(3);
         repeat (6) @(posedge pclk);
         latch = i / 2;
         `CHK(bootloader_mode, i == 3)
      end
      for (int j = 1; j >= 0; j--) begin
         {u_cpu_pin_model.capture_mode_select_pin, u_cpu_pin_model.irq_vpp_high} <= {1'b0, j[0]};
         repeat (3) @(posedge pclk);
         u_cpu_pin_model.pulse(2);
         repeat (3) @(posedge pclk);
         `CHK(bootloader_mode, j[0] & latch[0])
      end
      $display("mode tests done");
      apb(1'b0, addr_status, 32'h0);
      `CHK({rd[7], rd[3:0]}, {latch[0], 4'h2})
      apb(1'b0, 12'h00c, 32'h0);
      `CHK({err, rd}, 33'h100000000)
      apb(1'b1, addr_wdclr, $urandom & 32'hfffffffe);
      #1; // pulse launched at the access edge, look while it stands
      `CHK(watchdog_clear, 1'b1)
      $display("register tests done");
      stop_to_halt_option <= 1'b0;
      u_cpu_pin_model.pulse(0);
      #1; // mask pulse stands one cycle after the strobe edge
      `CHK({osc_enable, clear_imask, watchdog_run}, 3'h2)
      u_cpu_pin_model.timer_irq <= 1'b1;
      repeat ($urandom_range(50, 5)) @(posedge pclk);
      `CHK(osc_enable, 1'b0)
      u_cpu_pin_model.irq_n <= 1'b0;
      wake;
      `CHK(n >= stab_cycles && n <= stab_cycles + 6, 1'b1)
      stop_to_halt_option <= 1'b1;
      u_cpu_pin_model.pulse(0);
      #1;
      `CHK({osc_enable, cpu_clk_enable, timer_clk_enable, clear_imask}, 4'hb)
      repeat ($urandom_range(5000)) @(posedge pclk);
      u_cpu_pin_model.timer_irq <= 1'b1;
      wake;
      `CHK(n <= stab_cycles + 3, 1'b1)
      watchdog_enable_option <= 1'b0;
      u_cpu_pin_model.pulse(1);
      #1;
      `CHK({osc_enable, cpu_clk_enable, timer_clk_enable, clear_imask, watchdog_run}, 5'h16)
      u_cpu_pin_model.timer_irq <= 1'b1;
      wake;
      `CHK(n <= 4, 1'b1)
      $display("low power tests done");
      stop_test;
   end
endmodule : mode_select_low_power_ctrl_bench
